// *** common/supply_mode_defs.vh ***
// Constants for the supply, mode, reset and limp-home sequencer.
// Assumes a 25 MHz core clock and a 32-bit APB register port.
//
// How it works
// - Every reset restores registers and error flags
// - Serial access works while logic supply valid, except during soft reset delay
// - First frame after reset flags transfer error
// - Mux select 111 forces stand-by, channels off unless in limp-home
// - Idle: supply present, channels off, select differs
// - Limp-home input wakes device, pins drive channels
// - Soft reset bit equals power-on reset
// - Limp-home needs input high for ack time
// - Limp-home reset only with supply monitor set
// - Limp-home: pinned channels follow pins OR output register, others off
// - Limp-home: reads work, writes are discarded
// - Protection retries unlimited without logic supply
// - Current sense disabled during limp-home
// - Switch supply undervoltage forces outputs off
// - Limp-home forces OR input combination
`ifndef SUPPLY_MODE_DEFS_VH
`define SUPPLY_MODE_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_MUX         12'h004
`define OFS_OUTREG      12'h008
`define OFS_STATUS      12'h00c
`define OFS_IRQ_STAT    12'h010
`define OFS_IRQ_MASK    12'h014
`define OFS_RETRY       12'h018

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_SOFT_RST   0
`define CTRL_COMBINE    1
`define MUX_STANDBY     3'h7
`define MUX_RST         3'h7
`define OUT_RST         4'h0
`define RETRY_RST       4'h3
`define ST_STANDBY      0
`define ST_IDLE         1
`define ST_LIMP         2
`define ST_TER          3
`define ST_SUPMON       4
`define ST_LATCHED      8
`define EV_LIMP_ENTRY   0
`define EV_LATCH        1
`define EV_UV           2
`define EV_STANDBY      3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ         25
`define LIMP_ACK_MIN_US 5
`define LIMP_ACK_MAX_US 200
`define LIMP_ACK_CYC    (`LIMP_ACK_MIN_US * `CLK_MHZ)
`define SOFT_RST_US     100
`define SOFT_RST_CYC    (`SOFT_RST_US * `CLK_MHZ)
`define WAKEUP_US       200
`define WAKEUP_CYC      (`WAKEUP_US * `CLK_MHZ)
`define PROT_RETRY_CYC  16'd1000

`endif

// *** src/level_sync.v ***
// Two-flop synchroniser for asynchronous input levels.
// Assumes inputs are quasi-static compared with the core clock.
module level_sync #(
  parameter W = 1
) (
  input  wire         core_clk,  // Core clock
  input  wire         rstn,      // Async reset, active low
  input  wire [W-1:0] async_in,  // Asynchronous levels
  output wire [W-1:0] sync_out   // Synchronised levels
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // ----------------------------------------------------------------
  // Sync chain
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // level_sync

// *** src/high_timer.v ***
// Counts how long a synchronised level stays high.
// Assumes input already synchronised to core_clk.
module high_timer #(
  parameter W = 16
) (
  input  wire         core_clk,  // Core clock
  input  wire         rstn,      // Async reset, active low
  input  wire         level_in,  // Synchronised level
  input  wire [W-1:0] terminal,  // Terminal count
  output reg          qualified  // High once level held long enough
);
  reg [W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Any low cycle restarts, so glitches never qualify
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r     <= {W{1'b0}};
      qualified <= 1'b0;
    end else if (!level_in) begin
      cnt_r     <= {W{1'b0}};
      qualified <= 1'b0;
    end else if (cnt_r >= terminal) begin
      qualified <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // high_timer

// *** src/supply_mode_reset_limp_home.v ***
// Supply mode, reset and limp-home sequencer with APB registers.
// Assumes APB master on core_clk; supply and pin levels are async.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`include "supply_mode_defs.vh"

module supply_mode_reset_limp_home #(
  parameter NCH       = 4,
  parameter [NCH-1:0] PIN_MASK = 4'hf,
  parameter ACK_CYC   = `LIMP_ACK_CYC,
  parameter RST_CYC   = `SOFT_RST_CYC
) (
  input  wire           core_clk,             // Core clock 25 MHz
  input  wire           rstn,                 // Async reset, active low
  input  wire           psel,                 // APB select
  input  wire           penable,              // APB enable
  input  wire           pwrite,               // APB write
  input  wire [11:0]    paddr,                // APB byte address
  input  wire [31:0]    pwdata,               // APB write data
  output wire           pready,               // APB ready
  output reg  [31:0]    prdata,               // APB read data
  output wire           pslverr,              // APB error
  input  wire           logic_supply_ok,      // Logic supply valid
  input  wire           supply_monitor_flag,  // Switch supply above monitor
  input  wire           switch_uv,            // Switch supply undervoltage
  input  wire           limp_home_input,      // Limp-home pin
  input  wire [NCH-1:0] direct_channel_input, // Direct input pins
  input  wire [NCH-1:0] channel_fault,        // Per-channel overload
  input  wire           frame_done,           // Serial frame shifted out
  output reg  [NCH-1:0] channel_output,       // Channel on commands
  output reg            sense_enable,         // Current sense enable
  output wire           serial_ready,         // Serial access allowed
  output wire           irq                   // Interrupt level
);
  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  wire [NCH+4:0] sync_w;
  level_sync #(.W(NCH+5)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({direct_channel_input, limp_home_input, logic_supply_ok,
                supply_monitor_flag, switch_uv, frame_done}),
    .sync_out (sync_w)
  );
  wire [NCH-1:0] pin_s   = sync_w[NCH+4:5];
  wire           limp_s  = sync_w[4];
  wire           vdd_s   = sync_w[3];
  wire           smon_s  = sync_w[2];
  wire           uv_s    = sync_w[1];
  wire           frame_s = sync_w[0];

  // Limp-home high time qualification
  wire limp_ack;
  high_timer #(.W(16)) u_limp_timer (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .level_in  (limp_s),
    .terminal  (ACK_CYC[15:0]),
    .qualified (limp_ack)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [2:0]     mux_r;
  reg  [NCH-1:0] out_r;
  reg            combine_r;
  reg  [3:0]     retry_lim_r;
  reg  [3:0]     irq_stat_r;
  reg  [3:0]     irq_mask_r;
  reg            ter_r;
  reg            limp_r;
  reg  [NCH-1:0] latched_r;
  reg  [3:0]     retry_cnt_r [0:NCH-1];
  reg  [15:0]    rst_cnt_r;
  reg            frame_d_r;
  reg            limp_ack_d_r;
  reg            uv_d_r;
  reg            stb_d_r;
  reg  [NCH-1:0] fault_d_r;

  wire standby   = (mux_r == `MUX_STANDBY);
  wire idle      = vdd_s && !standby && (channel_output == {NCH{1'b0}});
  wire rst_busy  = (rst_cnt_r != 16'd0);
  wire wr_en     = psel && penable && pwrite && vdd_s;
  wire rd_en     = psel && penable && !pwrite;
  wire limp_entry = limp_ack && !limp_ack_d_r && smon_s;
  wire sw_reset  = wr_en && !limp_r && !rst_busy && (paddr == `OFS_CTRL)
                   && pwdata[`CTRL_SOFT_RST];
  // Writes drop silently during limp-home or reset delay
  wire wr_ok     = wr_en && !limp_r && !rst_busy;
  wire frame_end = frame_s && !frame_d_r;
  wire uv_rise   = uv_s && !uv_d_r;

  // Interrupt events
  wire [3:0] ev;
  assign ev[`EV_LIMP_ENTRY] = limp_entry;
  assign ev[`EV_LATCH]      = |(channel_fault & ~fault_d_r & ~latched_r);
  assign ev[`EV_UV]         = uv_rise;
  assign ev[`EV_STANDBY]    = standby && !stb_d_r;

  // Decode known offsets
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `OFS_CTRL) || (a == `OFS_MUX) || (a == `OFS_OUTREG) ||
                  (a == `OFS_STATUS) || (a == `OFS_IRQ_STAT) ||
                  (a == `OFS_IRQ_MASK) || (a == `OFS_RETRY);
    end
  endfunction

  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !is_mapped(paddr);
  assign serial_ready = vdd_s && !rst_busy;
  assign irq          = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Register file, reset sources and flags
  // ----------------------------------------------------------------
  // Soft reset and qualified limp entry clear like power-on, except irq status takes this cycle's events
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mux_r        <= `MUX_RST;
      out_r        <= `OUT_RST;
      combine_r    <= 1'b0;
      retry_lim_r  <= `RETRY_RST;
      irq_mask_r   <= 4'h0;
      irq_stat_r   <= 4'h0;
      ter_r        <= 1'b1;
      rst_cnt_r    <= 16'd0;
    end else if (sw_reset || limp_entry || !vdd_s) begin
      mux_r        <= `MUX_RST;
      out_r        <= `OUT_RST;
      combine_r    <= 1'b0;
      retry_lim_r  <= `RETRY_RST;
      irq_mask_r   <= 4'h0;
      irq_stat_r   <= ev;
      ter_r        <= 1'b1;
      rst_cnt_r    <= sw_reset ? RST_CYC[15:0] : 16'd0;
    end else begin
      if (rst_busy)
        rst_cnt_r <= rst_cnt_r - 16'd1;
      if (frame_end)
        ter_r <= 1'b0;
      if (wr_ok && paddr == `OFS_CTRL)
        combine_r <= pwdata[`CTRL_COMBINE];
      if (wr_ok && paddr == `OFS_MUX)
        mux_r <= pwdata[2:0];
      if (wr_ok && paddr == `OFS_OUTREG)
        out_r <= pwdata[NCH-1:0];
      if (wr_ok && paddr == `OFS_IRQ_MASK)
        irq_mask_r <= pwdata[3:0];
      if (wr_ok && paddr == `OFS_RETRY)
        retry_lim_r <= pwdata[3:0];
      // Set wins over write-one-to-clear
      if (wr_ok && paddr == `OFS_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~pwdata[3:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
    end
  end

  // ----------------------------------------------------------------
  // Limp-home mode and edge history
  // ----------------------------------------------------------------
  // Mode holds while pin stays high; works without logic supply
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      limp_r       <= 1'b0;
      frame_d_r    <= 1'b0;
      limp_ack_d_r <= 1'b0;
      uv_d_r       <= 1'b0;
      stb_d_r      <= 1'b0;
      fault_d_r    <= {NCH{1'b0}};
    end else begin
      if (!limp_s)
        limp_r <= 1'b0;
      else if (limp_ack)
        limp_r <= 1'b1;
      frame_d_r    <= frame_s;
      limp_ack_d_r <= limp_ack;
      uv_d_r       <= uv_s;
      stb_d_r      <= standby;
      fault_d_r    <= channel_fault;
    end
  end

  // ----------------------------------------------------------------
  // Protection retry and latch-off
  // ----------------------------------------------------------------
  // Limit only applies with logic supply; otherwise retry forever
  integer i;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      latched_r <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        retry_cnt_r[i] <= 4'h0;
    end else if (sw_reset || limp_entry) begin
      latched_r <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        retry_cnt_r[i] <= 4'h0;
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (channel_fault[i] && !fault_d_r[i] && !latched_r[i]) begin
          if (!vdd_s)
            retry_cnt_r[i] <= 4'h0;
          else if (retry_cnt_r[i] >= retry_lim_r)
            latched_r[i] <= 1'b1;
          else
            retry_cnt_r[i] <= retry_cnt_r[i] + 4'h1;
        end
        if (!vdd_s)
          latched_r[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel drive and current sense
  // ----------------------------------------------------------------
  reg [NCH-1:0] chan_nxt;
  always @* begin
    if (uv_s)
      chan_nxt = {NCH{1'b0}};
    else if (limp_r)
      chan_nxt = (out_r | pin_s) & PIN_MASK;
    else if (!vdd_s || standby)
      chan_nxt = {NCH{1'b0}};
    else if (combine_r)
      chan_nxt = out_r & pin_s & PIN_MASK;
    else
      chan_nxt = out_r | (pin_s & PIN_MASK);
    chan_nxt = chan_nxt & ~latched_r;
  end

  // Registered drive keeps outputs glitch free
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      channel_output <= {NCH{1'b0}};
      sense_enable   <= 1'b0;
    end else begin
      channel_output <= chan_nxt;
      sense_enable   <= vdd_s && !standby && !limp_r;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Reads stay available in limp-home
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_CTRL:     prdata <= {30'h0, combine_r, 1'b0};
        `OFS_MUX:      prdata <= {29'h0, mux_r};
        `OFS_OUTREG:   prdata <= {28'h0, out_r};
        `OFS_STATUS:   prdata <= {20'h0, latched_r, 3'h0, smon_s, ter_r,
                                  limp_r, idle, standby};
        `OFS_IRQ_STAT: prdata <= {28'h0, irq_stat_r};
        `OFS_IRQ_MASK: prdata <= {28'h0, irq_mask_r};
        `OFS_RETRY:    prdata <= {28'h0, retry_lim_r};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  wire unused_rd = rd_en;
endmodule // supply_mode_reset_limp_home

// *** verif/mode_checker_monitor.sv ***
// Port-level assertions for the supply mode sequencer.
// Assumes one core_clk domain; bound onto the top module below.
module mode_checker #(
  parameter NCH = 4
) (
  input logic           core_clk,             // Core clock
  input logic           rstn,                 // Async reset, active low
  input logic           psel,                 // APB select
  input logic           penable,              // APB enable
  input logic           pwrite,               // APB write
  input logic [11:0]    paddr,                // APB address
  input logic [31:0]    pwdata,               // APB write data
  input logic           logic_supply_ok,      // Logic supply valid
  input logic           switch_uv,            // Switch undervoltage
  input logic           limp_home_input,      // Limp-home pin
  input logic [NCH-1:0] direct_channel_input, // Direct pins
  input logic [NCH-1:0] channel_fault,        // Overload levels
  input logic [NCH-1:0] channel_output,       // Channel commands
  input logic           sense_enable,         // Sense enable
  input logic           serial_ready          // Serial access allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] lh_cnt_r; // Limp pin high time, saturating
  logic       flt_r;    // Fault seen: a latched channel may stay off

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Count limp pin high time and remember faults
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lh_cnt_r <= 6'h00;
      flt_r    <= 1'b0;
    end else begin
      lh_cnt_r <= !limp_home_input ? 6'h00 : lh_cnt_r + {5'h00, lh_cnt_r != 6'h3f};
      flt_r    <= flt_r | (|channel_fault);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_supply_gate: assert property ((!logic_supply_ok)[*4] |-> !serial_ready)
    else $error("serial access open without logic supply");
  chk_srst_drop: assert property (psel && penable && pwrite && paddr == 12'h000
    && pwdata[0] && serial_ready && !limp_home_input |-> ##[1:3] !serial_ready)
    else $error("soft reset did not close serial access");
  chk_srst_hold: assert property ($fell(serial_ready) && logic_supply_ok
    |-> (!serial_ready)[*8]) else $error("soft reset delay too short");
  chk_srst_back: assert property ($fell(serial_ready) && logic_supply_ok
    |-> ##[1:40] serial_ready) else $error("soft reset delay never ended");
  chk_uv_off: assert property (switch_uv[*6] |-> channel_output == '0)
    else $error("outputs on during undervoltage");
  chk_limp_sense: assert property (lh_cnt_r > 6'd20 |-> !sense_enable)
    else $error("current sense on in limp-home");
  chk_limp_pins: assert property ((lh_cnt_r > 6'd20 && !flt_r && !switch_uv
    && $stable(direct_channel_input))[*6]
    |-> (channel_output & direct_channel_input) == direct_channel_input)
    else $error("limp-home pin not driving its channel");
  chk_reset_off: assert property ($rose(rstn) |-> (channel_output == '0)[*8])
    else $error("channel on after reset");
endmodule // mode_checker

bind supply_mode_reset_limp_home mode_checker #(.NCH(NCH)) mode_checker_i (
  .core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .logic_supply_ok,
  .switch_uv, .limp_home_input, .direct_channel_input, .channel_fault,
  .channel_output, .sense_enable, .serial_ready);

// *** verif/frame_host.sv ***
// Host model: shifts one serial frame per start request.
// Assumes start rises on a core clock edge; link edges then land on core clock edges.
module frame_host (
  input  logic start,     // Begin one frame
  output logic frame_done // High once eight bits shifted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic link_clk; // Link clock, still between frames

  // Offset only delays the first wait; link edges still land on core clock edges
  initial begin
    link_clk   = 1'b0;
    frame_done = 1'b0;
    #7;
    forever begin
      @(posedge start);
      frame_done = 1'b0;
      repeat (16) #160 link_clk = ~link_clk;
      frame_done = 1'b1;
    end
  end
endmodule // frame_host

// *** verif/tb.sv ***
// Self-checking bench for the supply mode sequencer over APB.
// Assumes the shared defines header; 25 MHz core clock.
`include "supply_mode_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        supply_ok, mon_flag, uv, limp, frm_go, frm_done, sense_en, ser_rdy, irq, e;
  logic [3:0]  pins, ch_out;
  int          fail_count, cmp_count;

  supply_mode_reset_limp_home #(.ACK_CYC(4), .RST_CYC(10)) supply_mode_reset_limp_home_i (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .logic_supply_ok(supply_ok), .supply_monitor_flag(mon_flag), .switch_uv(uv),
    .limp_home_input(limp), .direct_channel_input(pins), .channel_fault(4'h0),
    .frame_done(frm_done), .channel_output(ch_out), .sense_enable(sense_en),
    .serial_ready(ser_rdy), .irq(irq));
  frame_host frame_host_i (.start(frm_go), .frame_done(frm_done));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Full transfer; the request holds until pready is seen high, for at most 20 edges
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("unexpected pready: expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never re-drives psel in this step
    @(posedge core_clk);
  endtask
  task automatic rd(input string w, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(w, x & m, q & m);
  endtask
  // Bounded wait on the frame flag (0) or serial access (1)
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    while ((sel == 0 ? frm_done : ser_rdy) !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if ((sel == 0 ? frm_done : ser_rdy) !== 1'b1) begin
      fail_count++;
      $display("unexpected wait_hi %0d: expected 1 seen 0", sel);
    end
  endtask

  // ----------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Tests need about 5300 cycles; cut a hang well beyond that
  initial begin
    cyc(20000);
    fail_count++;
    complete_run();
  end
  initial begin
    {psel, penable, pwrite, rstn, mon_flag, uv, limp, frm_go} = 8'h00;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    supply_ok = 1'b1;
    pins      = 4'hf;
    cyc(3);
    rstn <= 1'b1;
    cyc(`WAKEUP_CYC);
    rd("status", `OFS_STATUS, 32'hf1f, 32'h9);
    check("channel_output", 32'h0, {28'h0, ch_out});
    rd("mux", `OFS_MUX, 32'h7, 32'h7);
    rd("retry", `OFS_RETRY, 32'hf, 32'h3);
    apb(1'b0, 12'h01c, 32'h0);
    check("pslverr", 32'h1, {31'h0, e});
    pins <= 4'h0;
    apb(1'b1, `OFS_MUX, 32'h3);
    cyc(6);
    rd("status", `OFS_STATUS, 32'hf0f, 32'ha);
    frm_go <= 1'b1;
    cyc(1);
    frm_go <= 1'b0;
    wait_hi(0);
    cyc(6);
    rd("ter", `OFS_STATUS, 32'h8, 32'h0);
    // Interrupt: unmask only undervoltage, raise, mask, clear
    apb(1'b1, `OFS_IRQ_MASK, 32'h4);
    apb(1'b1, `OFS_IRQ_STAT, 32'hf);
    apb(1'b1, `OFS_OUTREG, 32'h5);
    cyc(6);
    check("irq", 32'h0, {31'h0, irq});
    check("channel_output", 32'h5, {28'h0, ch_out});
    uv <= 1'b1;
    cyc(8);
    check("channel_output", 32'h0, {28'h0, ch_out});
    check("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `OFS_IRQ_MASK, 32'hb);
    cyc(2);
    check("irq", 32'h0, {31'h0, irq});
    apb(1'b1, `OFS_IRQ_MASK, 32'h4);
    apb(1'b1, `OFS_IRQ_STAT, 32'h4);
    cyc(2);
    check("irq", 32'h0, {31'h0, irq});
    uv <= 1'b0;
    // Glitch on the limp pin shorter than the acknowledge time
    pins     <= 4'ha;
    mon_flag <= 1'b1;
    limp     <= 1'b1;
    cyc(2);
    limp <= 1'b0;
    cyc(10);
    rd("out", `OFS_OUTREG, 32'hf, 32'h5);
    check("channel_output", 32'hf, {28'h0, ch_out});
    // Limp-home without, then with, the supply monitor flag
    mon_flag <= 1'b0;
    limp     <= 1'b1;
    cyc(30);
    check("channel_output", 32'hf, {28'h0, ch_out});
    check("sense_enable", 32'h0, {31'h0, sense_en});
    rd("out", `OFS_OUTREG, 32'hf, 32'h5);
    rd("limp", `OFS_STATUS, 32'h4, 32'h4);
    apb(1'b1, `OFS_OUTREG, 32'h0);
    rd("out", `OFS_OUTREG, 32'hf, 32'h5);
    limp     <= 1'b0;
    mon_flag <= 1'b1;
    cyc(10);
    limp <= 1'b1;
    cyc(30);
    check("channel_output", 32'ha, {28'h0, ch_out});
    rd("out", `OFS_OUTREG, 32'hf, 32'h0);
    limp <= 1'b0;
    cyc(10);
    // Soft reset, then loss of logic supply
    apb(1'b1, `OFS_MUX, 32'h3);
    apb(1'b1, `OFS_CTRL, 32'h1);
    cyc(2);
    check("serial_ready", 32'h0, {31'h0, ser_rdy});
    wait_hi(1);
    rd("mux", `OFS_MUX, 32'h7, 32'h7);
    rd("ter", `OFS_STATUS, 32'h8, 32'h8);
    supply_ok <= 1'b0;
    cyc(6);
    check("serial_ready", 32'h0, {31'h0, ser_rdy});
    supply_ok <= 1'b1;
    wait_hi(1);
    check("serial_ready", 32'h1, {31'h0, ser_rdy});
    complete_run();
  end
endmodule // tb
